// >>> fcpc_chk_sva.sv
// port assertions of the flash controller
`timescale 1ns/1ps
`default_nettype none
module fcpc_chk
   import fcpc_pkg::*;
#(parameter int CODE_BYTES = 32'h0008_0000) (
   input wire logic mclk, reset, avs_read, avs_waitrequest, flash_rd_req,
   input wire logic erase_cycle, hard_fault, access_port_protection, pof_enable, pof_warning,
   input wire logic [11:0]   avs_address,
   input wire logic [31:0]   avs_readdata,
   input wire fcpc_pkg::fcpc_flash_cmd_s flash_cmd
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   AST_USER_BLOCK: assert property ($rose(flash_cmd.op == FCPC_OP_USER_ERASE) |->
      !$past(access_port_protection)) else $error("user erase under protection");
   AST_POF_IDLE: assert property ((pof_enable && pof_warning) [*2] |->
      flash_cmd.op == FCPC_OP_NONE) else $error("operation during power fail");
   AST_HF_NO_WRITE: assert property (hard_fault |->
      (flash_cmd.op != FCPC_OP_WRITE) [*2]) else $error("write despite hard fault");
   AST_PART_CODE: assert property (flash_cmd.op == FCPC_OP_PARTIAL |->
      flash_cmd.addr < CODE_BYTES) else $error("partial erase outside code area");
   AST_ERASE_CYC: assert property (erase_cycle |->
      $past(flash_cmd.page_done) || $past(flash_cmd.page_done, 2)) else $error("stray cycle");
   AST_ERASE_PULSE: assert property (erase_cycle |=> !erase_cycle)
      else $error("erase cycle counted twice");
   AST_STALL: assert property (flash_cmd.op == FCPC_OP_PARTIAL &&
      $past(flash_cmd.op) == FCPC_OP_PARTIAL |-> !flash_rd_req) else $error("fetch in erase");
   AST_READ_ANS: assert property ($rose(avs_read) |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("read answer timing");
   AST_BUSY_READ: assert property (avs_read && !avs_waitrequest &&
      avs_address == FCPC_OFF_READY && flash_cmd.op != FCPC_OP_NONE &&
      $past(flash_cmd.op) != FCPC_OP_NONE |-> !avs_readdata[0]) else $error("ready while busy");
   CV_PART: cover property (flash_cmd.op == FCPC_OP_PARTIAL);
   CV_ECYC: cover property (erase_cycle);
   CV_HF: cover property (hard_fault);
endmodule // fcpc_chk
bind fcpc_top fcpc_chk #(.CODE_BYTES(CODE_BYTES)) u_chk (.*);
`default_nettype wire

// >>> fcpc_flash_model.sv
// flash array model answering fetch reads after a settable delay
`timescale 1ns/1ps
`default_nettype none
module fcpc_flash_model (
   input  wire logic        mclk,
   input  wire logic [3:0]  lat,
   input  wire logic        rd_req,
   input  wire logic [31:0] rd_addr,
   output logic             rd_valid,
   output logic [31:0]      rd_data
);
   int          cnt = 0;
   logic [31:0] a   = '0;
   initial begin
      rd_valid = 1'b0;
      rd_data  = '0;
   end
   always @(posedge mclk) begin
      rd_valid <= 1'b0;
      // idle bus never keeps the last word
      rd_data  <= ~rd_data;
      if (rd_req) begin
         a   <= rd_addr;
         cnt <= int'(lat);
      end else if (cnt == 1) begin
         rd_valid <= 1'b1;
         rd_data  <= ~a ^ 32'h5A5A_0000;
         cnt      <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule // fcpc_flash_model
`default_nettype wire

// >>> fcpc_pkg.sv
// shared constants, register map and types of the flash controller block
package fcpc_pkg;

   // register byte offsets
   localparam logic [11:0] FCPC_OFF_READY      = 12'h400;
   localparam logic [11:0] FCPC_OFF_NEXT_WRITE_READY_FLAG  = 12'h408;
   localparam logic [11:0] FCPC_OFF_CONFIG     = 12'h504;
   localparam logic [11:0] FCPC_OFF_PAGE_ERASE = 12'h508;
   localparam logic [11:0] FCPC_OFF_FULL_ERASE = 12'h50C;
   localparam logic [11:0] FCPC_OFF_LEGACY0    = 12'h510;
   localparam logic [11:0] FCPC_OFF_USER_ERASE = 12'h514;
   localparam logic [11:0] FCPC_OFF_PARTIAL    = 12'h518;
   localparam logic [11:0] FCPC_OFF_PART_DUR   = 12'h51C;
   localparam logic [11:0] FCPC_OFF_ICACHE     = 12'h540;
   localparam logic [11:0] FCPC_OFF_ICACHE_HIT_COUNTER       = 12'h548;
   localparam logic [11:0] FCPC_OFF_ICACHE_MISS_COUNTER      = 12'h54C;

   // field positions and widths
   localparam int FCPC_READY_BIT    = 0;
   localparam int FCPC_MODE_LSB     = 0;
   localparam int FCPC_MODE_W       = 2;
   localparam int FCPC_CACHE_EN_BIT = 0;
   localparam int FCPC_PROF_EN_BIT  = 8;
   localparam int FCPC_DUR_W        = 7;

   // reset values
   localparam logic [31:0] FCPC_READY_RST    = 32'h0000_0001;
   localparam logic [31:0] FCPC_CONFIG_RST   = 32'h0000_0000;
   localparam logic [31:0] FCPC_PART_DUR_RST = 32'h0000_000A;
   localparam logic [31:0] FCPC_ICACHE_RST   = 32'h0000_0000;
   localparam logic [31:0] FCPC_COUNT_RST    = 32'h0000_0000;

   // timing
   localparam longint FCPC_CLK_PERIOD_PS   = 4000;
   localparam longint FCPC_PS_PER_MS       = 64'd1_000_000_000;
   localparam longint FCPC_WRITE_TIME_NS   = 41000;
   localparam int     FCPC_PAGE_ERASE_MS   = 85;
   localparam int     FCPC_FULL_ERASE_MS   = 170;

   typedef enum logic [1:0] {
      FCPC_MODE_READ  = 2'b00,
      FCPC_MODE_WRITE = 2'b01,
      FCPC_MODE_ERASE = 2'b10
   } fcpc_mode_e;

   typedef enum logic [2:0] {
      FCPC_OP_NONE       = 3'b000,
      FCPC_OP_WRITE      = 3'b001,
      FCPC_OP_PAGE_ERASE = 3'b010,
      FCPC_OP_FULL_ERASE = 3'b011,
      FCPC_OP_USER_ERASE = 3'b100,
      FCPC_OP_PARTIAL    = 3'b101
   } fcpc_op_e;

   // command held toward the flash array for the whole operation
   typedef struct packed {
      fcpc_op_e    op;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        page_done;
   } fcpc_flash_cmd_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } fcpc_wreq_s;

endpackage

// >>> fcpc_top.sv
// flash controller: protection, partial erase, write buffer, fetch cache, registers
// What this block does
// - with access port protection on, user area erase is blocked; others allowed
// - with power-fail comparator enabled and low supply, no erase or write happens
// - power-fail warning at erase start makes the erase request ignored
// - power-fail warning at write start raises a hard fault instead of writing
// - partial erase acts on code area pages only, never on user area
// - in erase mode a partial trigger write erases for the configured duration
// - erase time accumulates per page; page is erased when total reaches full time
// - each time the total reaches page erase time, one erase cycle is counted
// - a completed accumulated partial erase leaves every page bit at one
// - a page partly erased below the full time has undefined contents
// - instruction fetches stall while a partial erase chunk runs
// - optional fetch cache is enabled by the cache enable bit
// - a cache hit returns with zero wait states; a miss reads flash
// - disabling the cache invalidates every entry
// - with profiling on, hits and misses bump their counters
// - hit and miss counters saturate and never wrap
// - ready bit 0 reads 0 while writing or erasing, 1 when idle; resets to 1
// - legacy page erase register at 0x510 acts as the page erase trigger at 0x508
// - mode field: 0 read only, 1 write, 2 erase; bus-triggered operations need their mode
// - write or erase mode invalidates the cache and keeps it invalid
// - next write flag is 1 while one more word can be buffered
`timescale 1ns/1ps
`default_nettype none
module fcpc_top
   import fcpc_pkg::*;
#(
   parameter int MS_CYCLES     = int'(FCPC_PS_PER_MS / FCPC_CLK_PERIOD_PS),
   parameter int WRITE_CYCLES  = int'((FCPC_WRITE_TIME_NS * 1000 + FCPC_CLK_PERIOD_PS - 1)
                                      / FCPC_CLK_PERIOD_PS),
   parameter int PAGE_ERASE_MS = FCPC_PAGE_ERASE_MS,
   parameter int FULL_ERASE_MS = FCPC_FULL_ERASE_MS,
   parameter int CODE_BYTES    = 32'h0008_0000,
   parameter int PAGE_BYTES    = 4096,
   parameter int NPAGES        = 128,
   parameter int ACC_W         = 16,
   parameter int LINES         = 16
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     reset,
   // register bus
   input  wire logic [11:0]              avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   // word writes from the data bus
   input  wire logic                     nvm_wr_valid,
   input  wire fcpc_pkg::fcpc_wreq_s     nvm_wr_req,
   output logic                          nvm_wr_ready,
   // instruction fetch bus
   input  wire logic                     if_req,
   input  wire logic [31:0]              if_addr,
   output logic                          if_rvalid,
   output logic [31:0]                   if_rdata,
   // flash array
   output fcpc_pkg::fcpc_flash_cmd_s     flash_cmd,
   output logic                          flash_rd_req,
   output logic [31:0]                   flash_rd_addr,
   input  wire logic                     flash_rd_valid,
   input  wire logic [31:0]              flash_rd_data,
   output logic                          erase_cycle,
   // protection and supply status
   input  wire logic                     access_port_protection,
   input  wire logic                     pof_enable,
   input  wire logic                     pof_warning,
   input  wire logic                     dbg_full_erase,
   output logic                          hard_fault
);
   import fcpc_pkg::*;

   localparam int PG_W  = $clog2(NPAGES);
   localparam int PG_LSB = $clog2(PAGE_BYTES);
   localparam int IDX_W = $clog2(LINES);
   localparam int TAG_LSB = IDX_W + 2;

   typedef enum logic {
      FCPC_F_IDLE = 1'b0,
      FCPC_F_MISS = 1'b1
   } fcpc_fetch_e;

   // register bus state
   logic                 waitreq_r, waitreq_nxt;
   logic [31:0]          rdata_r, rdata_nxt;
   logic [1:0]           mode_r, mode_nxt;
   logic [FCPC_DUR_W-1:0] dur_r, dur_nxt;
   logic                 cache_en_r, cache_en_nxt;
   logic                 prof_en_r, prof_en_nxt;
   // operation state
   fcpc_flash_cmd_s      cmd_r, cmd_nxt;
   logic [31:0]          timer_r, timer_nxt;
   logic                 buf_valid_r, buf_valid_nxt;
   fcpc_wreq_s           buf_r, buf_nxt;
   logic                 wr_ready_r, wr_ready_nxt;
   logic                 fault_r, fault_nxt;
   logic                 cycle_r, cycle_nxt;
   logic [ACC_W-1:0]     acc_mem [NPAGES];
   logic                 acc_we, acc_clr_all;
   logic [PG_W-1:0]      acc_page;
   logic [ACC_W-1:0]     acc_wval;
   // fetch state
   fcpc_fetch_e          fst_r, fst_nxt;
   logic                 rvalid_r, rvalid_nxt;
   logic [31:0]          ifdata_r, ifdata_nxt;
   logic                 rd_req_r, rd_req_nxt;
   logic [31:0]          rd_addr_r, rd_addr_nxt;
   logic [31:0]          hit_r, hit_nxt;
   logic [31:0]          miss_r, miss_nxt;
   logic [LINES-1:0]     valid_r, valid_nxt;
   logic [31:0]          data_mem [LINES];
   logic [31-TAG_LSB:0]  tag_mem [LINES];
   logic                 fill_en;

   // shared decode
   logic                 busy, pof_block, acc_bus, wr_en, hold;
   logic                 trig_page, trig_full, trig_user, trig_part;
   logic [IDX_W-1:0]     fidx;
   logic                 cache_ok, hit;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return m;
   endfunction

   assign busy      = cmd_r.op != FCPC_OP_NONE;
   assign pof_block = pof_enable && pof_warning;
   assign acc_bus   = (avs_read || avs_write) && !waitreq_r;
   assign wr_en     = avs_write && acc_bus;
   // legacy triggers share the page erase path
   assign trig_page = wr_en && (avs_address[11:2] == FCPC_OFF_PAGE_ERASE[11:2] ||
                                avs_address[11:2] == FCPC_OFF_LEGACY0[11:2]);
   assign trig_full = wr_en && avs_address[11:2] == FCPC_OFF_FULL_ERASE[11:2];
   assign trig_user = wr_en && avs_address[11:2] == FCPC_OFF_USER_ERASE[11:2];
   assign trig_part = wr_en && avs_address[11:2] == FCPC_OFF_PARTIAL[11:2];
   // an erase trigger waits on the bus until the running operation ends
   assign hold = avs_write && busy &&
                 (avs_address[11:2] == FCPC_OFF_PAGE_ERASE[11:2] ||
                  avs_address[11:2] == FCPC_OFF_LEGACY0[11:2] ||
                  avs_address[11:2] == FCPC_OFF_FULL_ERASE[11:2] ||
                  avs_address[11:2] == FCPC_OFF_USER_ERASE[11:2] ||
                  avs_address[11:2] == FCPC_OFF_PARTIAL[11:2]);

   // register bus: one wait cycle unless an erase trigger is held, action at the edge waitrequest is low
   always_comb begin
      waitreq_nxt  = 1'b1;
      rdata_nxt    = rdata_r;
      mode_nxt     = mode_r;
      dur_nxt      = dur_r;
      cache_en_nxt = cache_en_r;
      prof_en_nxt  = prof_en_r;
      if ((avs_read || avs_write) && waitreq_r && !hold) begin
         waitreq_nxt = 1'b0;
         rdata_nxt   = 32'h0000_0000;
         case (avs_address[11:2])
            FCPC_OFF_READY[11:2]:
               rdata_nxt[FCPC_READY_BIT] = !busy && !buf_valid_r;
            FCPC_OFF_NEXT_WRITE_READY_FLAG[11:2]:
               rdata_nxt[FCPC_READY_BIT] = !buf_valid_r;
            FCPC_OFF_CONFIG[11:2]:
               rdata_nxt[FCPC_MODE_LSB +: FCPC_MODE_W] = mode_r;
            FCPC_OFF_PART_DUR[11:2]:
               rdata_nxt[FCPC_DUR_W-1:0] = dur_r;
            FCPC_OFF_ICACHE[11:2]: begin
               rdata_nxt[FCPC_CACHE_EN_BIT] = cache_en_r;
               rdata_nxt[FCPC_PROF_EN_BIT]  = prof_en_r;
            end
            FCPC_OFF_ICACHE_HIT_COUNTER[11:2]:  rdata_nxt = hit_r;
            FCPC_OFF_ICACHE_MISS_COUNTER[11:2]: rdata_nxt = miss_r;
            default:              rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         case (avs_address[11:2])
            FCPC_OFF_CONFIG[11:2]: begin
               // both narrow fields live in byte lane 0
               if (avs_byteenable[0]) begin
                  mode_nxt = avs_writedata[FCPC_MODE_LSB +: FCPC_MODE_W];
               end
            end
            FCPC_OFF_PART_DUR[11:2]: begin
               if (avs_byteenable[0]) begin
                  dur_nxt = avs_writedata[FCPC_DUR_W-1:0];
               end
            end
            FCPC_OFF_ICACHE[11:2]: begin
               if (avs_byteenable[0]) begin
                  cache_en_nxt = avs_writedata[FCPC_CACHE_EN_BIT];
               end
               if (avs_byteenable[1]) begin
                  prof_en_nxt = avs_writedata[FCPC_PROF_EN_BIT];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         waitreq_r  <= 1'b1;
         rdata_r    <= 32'h0000_0000;
         mode_r     <= FCPC_CONFIG_RST[FCPC_MODE_LSB +: FCPC_MODE_W];
         dur_r      <= FCPC_PART_DUR_RST[FCPC_DUR_W-1:0];
         cache_en_r <= FCPC_ICACHE_RST[FCPC_CACHE_EN_BIT];
         prof_en_r  <= FCPC_ICACHE_RST[FCPC_PROF_EN_BIT];
      end else begin
         waitreq_r  <= waitreq_nxt;
         rdata_r    <= rdata_nxt;
         mode_r     <= mode_nxt;
         dur_r      <= dur_nxt;
         cache_en_r <= cache_en_nxt;
         prof_en_r  <= prof_en_nxt;
      end
   end

   // operation sequencer: erases, buffered word writes, partial erase accounting
   always_comb begin
      logic [ACC_W:0]  sum;
      logic [PG_W-1:0] pg;
      logic            erase_ok;
      sum           = '0;
      pg            = avs_writedata[PG_LSB +: PG_W];
      erase_ok      = mode_r == FCPC_MODE_ERASE;
      cmd_nxt       = cmd_r;
      timer_nxt     = timer_r;
      buf_valid_nxt = buf_valid_r;
      buf_nxt       = buf_r;
      fault_nxt     = 1'b0;
      cycle_nxt     = 1'b0;
      acc_we        = 1'b0;
      acc_clr_all   = 1'b0;
      acc_page      = pg;
      acc_wval      = '0;
      if (nvm_wr_valid && wr_ready_r && mode_r == FCPC_MODE_WRITE) begin
         buf_valid_nxt = 1'b1;
         buf_nxt       = nvm_wr_req;
      end
      if (busy) begin
         if (pof_block) begin
            cmd_nxt = '0;
         end else if (timer_r == 32'h0000_0000) begin
            cycle_nxt = cmd_r.page_done;
            cmd_nxt   = '0;
         end else begin
            timer_nxt = timer_r - 32'h0000_0001;
         end
      end else if (dbg_full_erase || (erase_ok && (trig_full || trig_page || trig_user ||
                                                  trig_part))) begin
         // erase requests under a power warning vanish without a trace
         if (!pof_block) begin
            cmd_nxt.addr      = avs_writedata;
            cmd_nxt.wdata     = 32'hFFFF_FFFF;
            cmd_nxt.page_done = 1'b0;
            if (dbg_full_erase || trig_full) begin
               cmd_nxt.op  = FCPC_OP_FULL_ERASE;
               timer_nxt   = 32'(FULL_ERASE_MS * MS_CYCLES);
               acc_clr_all = 1'b1;
            end else if (trig_user) begin
               if (!access_port_protection) begin
                  cmd_nxt.op = FCPC_OP_USER_ERASE;
                  timer_nxt  = 32'(PAGE_ERASE_MS * MS_CYCLES);
               end
            end else if (avs_writedata < 32'(CODE_BYTES)) begin
               acc_we = 1'b1;
               if (trig_page) begin
                  cmd_nxt.op = FCPC_OP_PAGE_ERASE;
                  timer_nxt  = 32'(PAGE_ERASE_MS * MS_CYCLES);
               end else begin
                  cmd_nxt.op = FCPC_OP_PARTIAL;
                  timer_nxt  = 32'(32'(dur_r) * 32'(MS_CYCLES));
                  sum        = (ACC_W+1)'(acc_mem[pg]) + (ACC_W+1)'(dur_r);
                  if (sum >= (ACC_W+1)'(PAGE_ERASE_MS)) begin
                     // total reached: this chunk leaves the page all ones
                     cmd_nxt.page_done = 1'b1;
                  end else begin
                     // below the total the array marks the page undefined
                     acc_wval = sum[ACC_W-1:0];
                  end
               end
            end
         end
      end else if (buf_valid_r) begin
         buf_valid_nxt = 1'b0;
         if (pof_block) begin
            fault_nxt = 1'b1;
         end else begin
            cmd_nxt.op        = FCPC_OP_WRITE;
            cmd_nxt.addr      = buf_r.addr;
            cmd_nxt.wdata     = buf_r.data;
            cmd_nxt.page_done = 1'b0;
            timer_nxt         = 32'(WRITE_CYCLES);
         end
      end
      wr_ready_nxt = !buf_valid_nxt;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cmd_r       <= '0;
         timer_r     <= 32'h0000_0000;
         buf_valid_r <= 1'b0;
         buf_r       <= '0;
         wr_ready_r  <= 1'b1;
         fault_r     <= 1'b0;
         cycle_r     <= 1'b0;
      end else begin
         cmd_r       <= cmd_nxt;
         timer_r     <= timer_nxt;
         buf_valid_r <= buf_valid_nxt;
         buf_r       <= buf_nxt;
         wr_ready_r  <= wr_ready_nxt;
         fault_r     <= fault_nxt;
         cycle_r     <= cycle_nxt;
      end
   end

   // per-page accumulated partial erase time, in milliseconds
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int p = 0; p < NPAGES; p++) begin
            acc_mem[p] <= '0;
         end
      end else if (acc_clr_all) begin
         for (int p = 0; p < NPAGES; p++) begin
            acc_mem[p] <= '0;
         end
      end else if (acc_we) begin
         acc_mem[acc_page] <= acc_wval;
      end
   end

   // fetch engine with direct-mapped word cache
   assign cache_ok = cache_en_r && mode_r == FCPC_MODE_READ;
   assign fidx     = if_addr[2 +: IDX_W];
   assign hit      = cache_ok && valid_r[fidx] && tag_mem[fidx] == if_addr[31:TAG_LSB];

   always_comb begin
      fst_nxt     = fst_r;
      rvalid_nxt  = 1'b0;
      ifdata_nxt  = ifdata_r;
      rd_req_nxt  = 1'b0;
      rd_addr_nxt = rd_addr_r;
      hit_nxt     = hit_r;
      miss_nxt    = miss_r;
      valid_nxt   = cache_ok ? valid_r : '0;
      fill_en     = 1'b0;
      case (fst_r)
         FCPC_F_IDLE: begin
            // no fetch is taken while the array is busy
            if (if_req && !rvalid_r && !busy) begin
               if (hit) begin
                  rvalid_nxt = 1'b1;
                  ifdata_nxt = data_mem[fidx];
                  if (prof_en_r && hit_r != 32'hFFFF_FFFF) begin
                     hit_nxt = hit_r + 32'h0000_0001;
                  end
               end else begin
                  rd_req_nxt  = 1'b1;
                  rd_addr_nxt = if_addr;
                  fst_nxt     = FCPC_F_MISS;
                  if (cache_ok && prof_en_r && miss_r != 32'hFFFF_FFFF) begin
                     miss_nxt = miss_r + 32'h0000_0001;
                  end
               end
            end
         end
         FCPC_F_MISS: begin
            if (flash_rd_valid) begin
               rvalid_nxt = 1'b1;
               ifdata_nxt = flash_rd_data;
               fst_nxt    = FCPC_F_IDLE;
               if (cache_ok) begin
                  fill_en = 1'b1;
                  valid_nxt[rd_addr_r[2 +: IDX_W]] = 1'b1;
               end
            end
         end
         default: fst_nxt = FCPC_F_IDLE;
      endcase
      if (wr_en && avs_address[11:2] == FCPC_OFF_ICACHE_HIT_COUNTER[11:2]) begin
         hit_nxt = merge(hit_r, avs_writedata, avs_byteenable);
      end
      if (wr_en && avs_address[11:2] == FCPC_OFF_ICACHE_MISS_COUNTER[11:2]) begin
         miss_nxt = merge(miss_r, avs_writedata, avs_byteenable);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fst_r     <= FCPC_F_IDLE;
         rvalid_r  <= 1'b0;
         ifdata_r  <= 32'h0000_0000;
         rd_req_r  <= 1'b0;
         rd_addr_r <= 32'h0000_0000;
         hit_r     <= FCPC_COUNT_RST;
         miss_r    <= FCPC_COUNT_RST;
         valid_r   <= '0;
      end else begin
         fst_r     <= fst_nxt;
         rvalid_r  <= rvalid_nxt;
         ifdata_r  <= ifdata_nxt;
         rd_req_r  <= rd_req_nxt;
         rd_addr_r <= rd_addr_nxt;
         hit_r     <= hit_nxt;
         miss_r    <= miss_nxt;
         valid_r   <= valid_nxt;
      end
   end

   // cache payload needs no reset: valid bits guard it
   always_ff @(posedge mclk) begin
      if (fill_en) begin
         data_mem[rd_addr_r[2 +: IDX_W]] <= flash_rd_data;
         tag_mem[rd_addr_r[2 +: IDX_W]]  <= rd_addr_r[31:TAG_LSB];
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = waitreq_r;
   assign nvm_wr_ready    = wr_ready_r;
   assign if_rvalid       = rvalid_r;
   assign if_rdata        = ifdata_r;
   assign flash_cmd       = cmd_r;
   assign flash_rd_req    = rd_req_r;
   assign flash_rd_addr   = rd_addr_r;
   assign erase_cycle     = cycle_r;
   assign hard_fault      = fault_r;

endmodule // fcpc_top
`default_nettype wire

// >>> tb.sv
// self-checking bench of the flash controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fcpc_pkg::*;
   logic mclk, reset, avs_read, avs_write, avs_waitrequest, nvm_wr_valid, nvm_wr_ready, if_req;
   logic if_rvalid, flash_rd_req, flash_rd_valid, erase_cycle, hard_fault, dbg_full_erase;
   logic access_port_protection, pof_enable, pof_warning;
   logic [11:0] avs_address;
   logic [3:0]  avs_byteenable, lat;
   logic [31:0] avs_writedata, avs_readdata, if_addr, if_rdata, flash_rd_addr, flash_rd_data, a;
   logic [31:0] lfsr = 32'h0000_000E;
   fcpc_wreq_s      nvm_wr_req;
   fcpc_flash_cmd_s flash_cmd;
   logic [31:0] expq[$];
   int err_total = 0, n_tests = 0, hf_n = 0, ec_n = 0, wr_n = 0;
   localparam logic [11:0] RA [7] = '{FCPC_OFF_READY, FCPC_OFF_CONFIG, FCPC_OFF_PART_DUR,
      FCPC_OFF_ICACHE, FCPC_OFF_ICACHE_HIT_COUNTER, FCPC_OFF_ICACHE_MISS_COUNTER, 12'h7FC};
   localparam logic [31:0] RV [7] = '{32'h1, 32'h0, 32'hA, 32'h0, 32'h0, 32'h0, 32'h0};
   fcpc_top #(.MS_CYCLES(2), .WRITE_CYCLES(3), .PAGE_ERASE_MS(4)) u_dut (.*);
   fcpc_flash_model u_fl (.mclk(mclk), .lat(lat), .rd_req(flash_rd_req),
      .rd_addr(flash_rd_addr), .rd_valid(flash_rd_valid), .rd_data(flash_rd_data));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int i;
      i = 0;
      if (!w) expq.push_back(d);
      avs_address <= ad; avs_writedata <= d; avs_read <= !w; avs_write <= w;
      do begin @(posedge mclk); i++; end while (avs_waitrequest !== 1'b0 && i < 200);
      if (i >= 200) begin err_total++; close_out(); end
      avs_read <= 1'b0; avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   // lat_exp of zero leaves the answer time open (miss)
   task automatic fetch(input logic [31:0] ad, input int lat_exp);
      int i;
      i = 0;
      expq.push_back(~ad ^ 32'h5A5A_0000);
      if_addr <= ad; if_req <= 1'b1;
      do begin @(posedge mclk); i++; end while (if_rvalid !== 1'b1 && i < 200);
      if (i >= 200) begin err_total++; close_out(); end
      if_req <= 1'b0;
      if (lat_exp > 0) chk(i, lat_exp);
      @(posedge mclk);
   endtask
   always @(posedge mclk) begin
      if (avs_read && !avs_waitrequest) chk(avs_readdata, expq.pop_front());
      if (if_rvalid) chk(if_rdata, expq.pop_front());
      hf_n += int'(hard_fault);
      wr_n += int'(!nvm_wr_ready);
      ec_n += int'(erase_cycle);
   end
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      reset = 1'b1; {avs_read, avs_write, nvm_wr_valid, if_req, dbg_full_erase} = '0;
      {access_port_protection, pof_enable, pof_warning} = '0;
      avs_address = '0; avs_writedata = '0; avs_byteenable = 4'hF; if_addr = '0;
      nvm_wr_req = '0; lat = 4'h1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      for (int k = 0; k < 7; k++) bus(1'b0, RA[k], RV[k]);
      lfsr = lfsr_next(lfsr);
      a = lfsr & 32'h0000_FFFC;
      bus(1'b1, FCPC_OFF_ICACHE, 32'h101);
      fetch(a, 0); fetch(a, 2);
      bus(1'b0, FCPC_OFF_ICACHE_HIT_COUNTER, 32'h1); bus(1'b0, FCPC_OFF_ICACHE_MISS_COUNTER, 32'h1);
      bus(1'b1, FCPC_OFF_ICACHE, 32'h0); bus(1'b1, FCPC_OFF_ICACHE, 32'h101);
      lat <= 4'h6; fetch(a, 0); bus(1'b0, FCPC_OFF_ICACHE_MISS_COUNTER, 32'h2);
      bus(1'b1, FCPC_OFF_ICACHE_HIT_COUNTER, 32'hFFFF_FFFF); fetch(a, 2);
      bus(1'b0, FCPC_OFF_ICACHE_HIT_COUNTER, 32'hFFFF_FFFF);
      bus(1'b1, FCPC_OFF_CONFIG, 32'h2); bus(1'b1, FCPC_OFF_PART_DUR, 32'h2);
      repeat (2) begin
         bus(1'b1, FCPC_OFF_PARTIAL, 32'h2000); bus(1'b0, FCPC_OFF_READY, 32'h0);
         fetch(a, 0);
         repeat (8) @(posedge mclk);
      end
      chk(ec_n, 1);
      bus(1'b1, FCPC_OFF_PARTIAL, 32'h1000_0000); bus(1'b0, FCPC_OFF_READY, 32'h1);
      bus(1'b1, FCPC_OFF_USER_ERASE, 32'h0); repeat (12) @(posedge mclk);
      access_port_protection <= 1'b1;
      bus(1'b1, FCPC_OFF_USER_ERASE, 32'h0); bus(1'b0, FCPC_OFF_READY, 32'h1);
      bus(1'b1, FCPC_OFF_LEGACY0, 32'h3000); bus(1'b0, FCPC_OFF_READY, 32'h0);
      repeat (12) @(posedge mclk);
      dbg_full_erase <= 1'b1;
      @(posedge mclk);
      dbg_full_erase <= 1'b0;
      bus(1'b0, FCPC_OFF_READY, 32'h0);
      access_port_protection <= 1'b0; pof_enable <= 1'b1; pof_warning <= 1'b1;
      bus(1'b1, FCPC_OFF_PAGE_ERASE, 32'h3000); bus(1'b0, FCPC_OFF_READY, 32'h1);
      bus(1'b1, FCPC_OFF_CONFIG, 32'h1);
      nvm_wr_req <= '{addr: 32'h4000, data: lfsr}; nvm_wr_valid <= 1'b1;
      @(posedge mclk);
      nvm_wr_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(hf_n, 1);
      chk(wr_n, 1);
      bus(1'b0, FCPC_OFF_NEXT_WRITE_READY_FLAG, 32'h1);
      pof_enable <= 1'b0; pof_warning <= 1'b0;
      bus(1'b1, FCPC_OFF_CONFIG, 32'h0);
      bus(1'b1, FCPC_OFF_PARTIAL, 32'h2000); bus(1'b0, FCPC_OFF_READY, 32'h1);
      fetch(a, 0); bus(1'b0, FCPC_OFF_ICACHE_MISS_COUNTER, 32'h3);
      close_out();
   end
endmodule // tb
`default_nettype wire
